// *** src/rmx_pkg.sv ***
package rmx_pkg;

  // operand widths and file sizes
  localparam int unsigned GR_W          = 64;
  localparam int unsigned PRED_CNT      = 64;
  localparam int unsigned STATIC_PRED_N = 16;
  localparam int unsigned ROT_PRED_N    = 48;
  localparam int unsigned MASK_FIELD_W  = 16;
  localparam int unsigned MASK_W        = 17;
  localparam int unsigned ROT_FIELD_W   = 28;
  localparam int unsigned ROT_IMM_W     = 44;
  localparam int unsigned ROT_SHIFT     = 16;
  localparam int unsigned IMM22_W       = 22;
  localparam int unsigned IND_INDEX_W   = 8;
  localparam int unsigned BR_CNT        = 8;
  localparam int unsigned BR_IDX_W      = 3;
  localparam int unsigned QP_IDX_W      = 6;
  localparam int unsigned OP_W          = 4;
  localparam int unsigned ADDR_W        = 8;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_IMM    = 8'h04;
  localparam logic [7:0] OFF_SRC_LO = 8'h08;
  localparam logic [7:0] OFF_SRC_HI = 8'h0c;
  localparam logic [7:0] OFF_SRC_NT = 8'h10;
  localparam logic [7:0] OFF_IP_LO  = 8'h14;
  localparam logic [7:0] OFF_IP_HI  = 8'h18;
  localparam logic [7:0] OFF_RES_LO = 8'h1c;
  localparam logic [7:0] OFF_RES_HI = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  localparam logic [7:0] OFF_PR_LO  = 8'h28;
  localparam logic [7:0] OFF_PR_HI  = 8'h2c;
  localparam logic [7:0] OFF_BR_LO  = 8'h30;
  localparam logic [7:0] OFF_BR_HI  = 8'h34;

  // control field positions
  localparam int unsigned CTRL_OP_LSB = 0;
  localparam int unsigned CTRL_QP_LSB = 4;
  localparam int unsigned CTRL_BR_LSB = 10;
  localparam int unsigned CTRL_IREG   = 13;
  localparam int unsigned CTRL_GO     = 14;

  // status field positions
  localparam int unsigned ST_RES_NAT  = 0;
  localparam int unsigned ST_GR_WR    = 1;
  localparam int unsigned ST_BR_WR    = 2;
  localparam int unsigned ST_PR_WR    = 3;
  localparam int unsigned ST_NAT_FLT  = 4;
  localparam int unsigned ST_RSV_FLT  = 5;
  localparam int unsigned ST_SKIPPED  = 6;
  localparam int unsigned ST_W        = 7;

  // reset values
  localparam logic [31:0]   REG_RST  = 32'h0000_0000;
  localparam logic [63:0]   WIDE_RST = 64'h0000_0000_0000_0000;
  localparam logic [ST_W-1:0] ST_RST = 7'h00;

  typedef enum logic [OP_W-1:0] {
    RMX_OP_FROM_BR,
    RMX_OP_TO_BR,
    RMX_OP_FROM_IND,
    RMX_OP_FROM_IP,
    RMX_OP_FROM_PR,
    RMX_OP_TO_PR,
    RMX_OP_TO_PR_ROT,
    RMX_OP_MOV_IMM,
    RMX_OP_MOV_GR
  } rmx_op_t;

  typedef enum logic {
    RMX_IREG_CPUID,
    RMX_IREG_PMD
  } rmx_ireg_t;

endpackage

// *** src/rmx_if.sv ***
interface rmx_pred_if;
  logic                        we;
  logic [rmx_pkg::GR_W-1:0]    mask;
  logic [rmx_pkg::GR_W-1:0]    data;
  logic [rmx_pkg::GR_W-1:0]    rd;
  modport owner (input we, input mask, input data, output rd);
  modport user  (output we, output mask, output data, input rd);
endinterface

interface rmx_ind_if;
  rmx_pkg::rmx_ireg_t               sel;
  logic [rmx_pkg::IND_INDEX_W-1:0]  index;
  logic                             retire;
  logic [rmx_pkg::OP_W-1:0]         op;
  logic [rmx_pkg::GR_W-1:0]         data;
  logic                             reserved;
  modport owner (input sel, input index, input retire, input op, output data, output reserved);
  modport user  (output sel, output index, output retire, output op, input data, input reserved);
endinterface

// *** src/rmx_pred_file.sv ***
module rmx_pred_file (
  // clock and reset
  input wire logic    pclk,
  input wire logic    presetn,
  input wire logic    clk_en,
  // predicate port
  rmx_pred_if.owner   pbus
);

  typedef struct packed {
    logic [rmx_pkg::GR_W-1:0] pr;
  } rmx_pred_st_t;

  rmx_pred_st_t st_ff;
  rmx_pred_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (pbus.we) begin
      // masked merge keeps every unselected predicate [RL11]
      nxt_st.pr = (st_ff.pr & ~pbus.mask) | (pbus.data & pbus.mask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // predicate zero is hardwired, whatever was written [RL13]
  assign pbus.rd = {st_ff.pr[rmx_pkg::GR_W-1:1], 1'b1};

endmodule

// *** src/rmx_ind_read.sv ***
module rmx_ind_read #(
  parameter int unsigned CPUID_CNT = 5,
  parameter int unsigned PMD_CNT   = 4,
  // arbitrary tag placed above the index in identification entries
  parameter logic [55:0] CPUID_TAG = 56'h5a5a_5a5a_5a5a_5a
) (
  // clock and reset
  input wire logic    pclk,
  input wire logic    presetn,
  input wire logic    clk_en,
  // lookup port
  rmx_ind_if.owner    ibus
);

  typedef struct packed {
    logic [PMD_CNT-1:0][rmx_pkg::GR_W-1:0] cnt;
  } rmx_ind_st_t;

  rmx_ind_st_t st_ff;
  rmx_ind_st_t nxt_st;

  // performance data: counter i counts retired moves of op code i
  always_comb begin
    nxt_st = st_ff;
    for (int i = 0; i < PMD_CNT; i++) begin
      if (ibus.retire && ibus.op == rmx_pkg::OP_W'(i)) begin
        nxt_st.cnt[i] = st_ff.cnt[i] + 64'h0000_0000_0000_0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    ibus.data     = '0;
    ibus.reserved = 1'b0;
    if (ibus.sel == rmx_pkg::RMX_IREG_CPUID) begin
      if ({1'b0, ibus.index} >= 9'(CPUID_CNT)) begin
        ibus.reserved = 1'b1; // [RL6]
      end else begin
        ibus.data = {CPUID_TAG, ibus.index}; // [RL5]
      end
    end else begin
      // unimplemented performance entries read zero and never fault [RL7]
      for (int i = 0; i < PMD_CNT; i++) begin
        if ({1'b0, ibus.index} == 9'(i)) begin
          ibus.data = st_ff.cnt[i]; // [RL5]
        end
      end
    end
  end

endmodule

// *** src/rmx_top.sv ***
// Notes on behaviour
// RL1 - branch read copies branch reg to result and clears result token
// RL2 - branch write copies source; set source token faults and writes nothing
// RL3 - false qualifying predicate: no state change, no fault
// RL4 - indirect index is source bits 7:0 only
// RL5 - file select picks identification or performance data; entry goes to result
// RL6 - nonexistent identification index raises reserved register fault
// RL7 - performance data reads never fault; unimplemented entries read zero
// RL8 - index token fault before reserved check; success clears result token
// RL9 - ip read returns bundle address and clears result token
// RL10 - predicate read puts predicate n at result bit n
// RL11 - masked predicate write changes only predicates with mask bit set
// RL12 - 17-bit mask rebuilt from 16-bit field shifted, sign extended over rotating
// RL13 - predicate zero always reads one
// RL14 - masked predicate write with source token faults, updates nothing
// RL15 - rotating immediate write touches only the 48 rotating predicates
// RL16 - rotating operand from 28-bit field shifted by 16, sign extended
// RL17 - predicates addressed as if rotation base were zero
// RL18 - move immediate sign extends 22 bits to 64, plus register zero
// RL19 - general move adds immediate zero to source
module rmx_top (
  // clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         clk_en,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [rmx_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                  pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr
);

  typedef struct packed {
    logic [31:0]                                       ctrl;
    logic [31:0]                                       imm;
    logic [rmx_pkg::GR_W-1:0]                          src;
    logic                                              src_nat;
    logic [rmx_pkg::GR_W-1:0]                          ip;
    logic [rmx_pkg::GR_W-1:0]                          res;
    logic [rmx_pkg::ST_W-1:0]                          stat;
    logic [rmx_pkg::BR_CNT-1:0][rmx_pkg::GR_W-1:0]     br;
    logic                                              pend;
    logic                                              rdy;
    logic [31:0]                                       rdata;
    logic                                              err;
  } rmx_top_st_t;

  ////////////////////////////////////////////////////////////////////////////////

  function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic addr_mapped(input logic [rmx_pkg::ADDR_W-1:0] a);
    logic m;
    m = 1'b0;
    unique case (a)
      rmx_pkg::OFF_CTRL, rmx_pkg::OFF_IMM, rmx_pkg::OFF_SRC_LO, rmx_pkg::OFF_SRC_HI,
      rmx_pkg::OFF_SRC_NT, rmx_pkg::OFF_IP_LO, rmx_pkg::OFF_IP_HI, rmx_pkg::OFF_RES_LO,
      rmx_pkg::OFF_RES_HI, rmx_pkg::OFF_STATUS, rmx_pkg::OFF_PR_LO, rmx_pkg::OFF_PR_HI,
      rmx_pkg::OFF_BR_LO, rmx_pkg::OFF_BR_HI: m = 1'b1;
      default: m = 1'b0;
    endcase
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  rmx_top_st_t st_ff;
  rmx_top_st_t nxt_st;

  rmx_pred_if pred_bus();
  rmx_ind_if  ind_bus();

  rmx_pred_file rmx_pred_file_i (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .pbus    (pred_bus)
  );

  rmx_ind_read rmx_ind_read_i (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .ibus    (ind_bus)
  );

  logic [rmx_pkg::OP_W-1:0]     op_code;
  logic [rmx_pkg::QP_IDX_W-1:0] qp_idx;
  logic [rmx_pkg::BR_IDX_W-1:0] br_idx;
  logic                         qp_true;
  logic [rmx_pkg::GR_W-1:0]     sel_br;
  logic [rmx_pkg::GR_W-1:0]     mask_ext;
  logic [rmx_pkg::GR_W-1:0]     rot_ext;
  logic [rmx_pkg::GR_W-1:0]     imm_ext;
  logic                         apb_setup;
  logic                         apb_acc;
  logic                         pr_we;
  logic [rmx_pkg::GR_W-1:0]     pr_mask;
  logic [rmx_pkg::GR_W-1:0]     pr_data;
  logic                         retire;

  assign op_code   = st_ff.ctrl[rmx_pkg::CTRL_OP_LSB +: rmx_pkg::OP_W];
  assign qp_idx    = st_ff.ctrl[rmx_pkg::CTRL_QP_LSB +: rmx_pkg::QP_IDX_W];
  assign br_idx    = st_ff.ctrl[rmx_pkg::CTRL_BR_LSB +: rmx_pkg::BR_IDX_W];
  // rotation base treated as zero: predicate n is file bit n [RL17]
  assign qp_true   = pred_bus.rd[qp_idx];
  assign sel_br    = st_ff.br[br_idx];
  // field holds mask >> 1; bit 0 of the mask is predicate zero and stays clear [RL12]
  assign mask_ext  = {{(rmx_pkg::GR_W - rmx_pkg::MASK_FIELD_W){st_ff.imm[15]}},
                      st_ff.imm[14:0], 1'b0};
  // field holds the 44-bit value >> 16; sign bit fills the top 21 predicates [RL16]
  assign rot_ext   = {{(rmx_pkg::GR_W - rmx_pkg::ROT_IMM_W){st_ff.imm[27]}},
                      st_ff.imm[rmx_pkg::ROT_FIELD_W-1:0], 16'h0000};
  assign imm_ext   = {{(rmx_pkg::GR_W - rmx_pkg::IMM22_W){st_ff.imm[21]}},
                      st_ff.imm[rmx_pkg::IMM22_W-1:0]};
  assign apb_setup = psel && !penable;
  assign apb_acc   = psel && penable && st_ff.rdy;

  assign pred_bus.we    = pr_we;
  assign pred_bus.mask  = pr_mask;
  assign pred_bus.data  = pr_data;
  assign ind_bus.sel    = rmx_pkg::rmx_ireg_t'(st_ff.ctrl[rmx_pkg::CTRL_IREG]);
  assign ind_bus.index  = st_ff.src[rmx_pkg::IND_INDEX_W-1:0]; // [RL4]
  assign ind_bus.retire = retire;
  assign ind_bus.op     = op_code;

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    nxt_st  = st_ff;
    pr_we   = 1'b0;
    pr_mask = '0;
    pr_data = '0;
    retire  = 1'b0;

    // read data and error prepared in setup, shown during the single access cycle
    if (apb_setup && !st_ff.rdy) begin
      nxt_st.rdy   = 1'b1;
      nxt_st.err   = !addr_mapped(paddr);
      nxt_st.rdata = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          rmx_pkg::OFF_CTRL:   nxt_st.rdata = st_ff.ctrl;
          rmx_pkg::OFF_IMM:    nxt_st.rdata = st_ff.imm;
          rmx_pkg::OFF_SRC_LO: nxt_st.rdata = st_ff.src[31:0];
          rmx_pkg::OFF_SRC_HI: nxt_st.rdata = st_ff.src[63:32];
          rmx_pkg::OFF_SRC_NT: nxt_st.rdata = {31'h0000_0000, st_ff.src_nat};
          rmx_pkg::OFF_IP_LO:  nxt_st.rdata = st_ff.ip[31:0];
          rmx_pkg::OFF_IP_HI:  nxt_st.rdata = st_ff.ip[63:32];
          rmx_pkg::OFF_RES_LO: nxt_st.rdata = st_ff.res[31:0];
          rmx_pkg::OFF_RES_HI: nxt_st.rdata = st_ff.res[63:32];
          rmx_pkg::OFF_STATUS: nxt_st.rdata = {25'h000_0000, st_ff.stat};
          rmx_pkg::OFF_PR_LO:  nxt_st.rdata = pred_bus.rd[31:0];
          rmx_pkg::OFF_PR_HI:  nxt_st.rdata = pred_bus.rd[63:32];
          rmx_pkg::OFF_BR_LO:  nxt_st.rdata = sel_br[31:0];
          rmx_pkg::OFF_BR_HI:  nxt_st.rdata = sel_br[63:32];
          default:             nxt_st.rdata = 32'h0000_0000;
        endcase
      end
    end else if (apb_acc) begin
      nxt_st.rdy = 1'b0;
    end

    // writes land on the access edge; read-only offsets ignore writes silently
    if (apb_acc && pwrite && !st_ff.err) begin
      unique case (paddr)
        rmx_pkg::OFF_CTRL: begin
          nxt_st.ctrl = strb_merge(st_ff.ctrl, pwdata, pstrb);
          nxt_st.ctrl[rmx_pkg::CTRL_GO] = 1'b0;
          nxt_st.pend = pstrb[1] && pwdata[rmx_pkg::CTRL_GO];
        end
        rmx_pkg::OFF_IMM:    nxt_st.imm = strb_merge(st_ff.imm, pwdata, pstrb);
        rmx_pkg::OFF_SRC_LO: nxt_st.src[31:0] = strb_merge(st_ff.src[31:0], pwdata, pstrb);
        rmx_pkg::OFF_SRC_HI: nxt_st.src[63:32] = strb_merge(st_ff.src[63:32], pwdata, pstrb);
        rmx_pkg::OFF_SRC_NT: begin
          if (pstrb[0]) begin
            nxt_st.src_nat = pwdata[0];
          end
        end
        rmx_pkg::OFF_IP_LO:  nxt_st.ip[31:0] = strb_merge(st_ff.ip[31:0], pwdata, pstrb);
        rmx_pkg::OFF_IP_HI:  nxt_st.ip[63:32] = strb_merge(st_ff.ip[63:32], pwdata, pstrb);
        default: ;
      endcase
    end

    // one move executes in the cycle after its go write
    if (st_ff.pend) begin
      nxt_st.pend = 1'b0;
      nxt_st.stat = rmx_pkg::ST_RST;
      if (!qp_true) begin
        nxt_st.stat[rmx_pkg::ST_SKIPPED] = 1'b1; // [RL3]
      end else begin
        retire = 1'b1;
        unique case (rmx_pkg::rmx_op_t'(op_code))
          rmx_pkg::RMX_OP_FROM_BR: begin
            nxt_st.res = sel_br; // [RL1]
            nxt_st.stat[rmx_pkg::ST_GR_WR] = 1'b1;
          end
          rmx_pkg::RMX_OP_TO_BR: begin
            if (st_ff.src_nat) begin
              nxt_st.stat[rmx_pkg::ST_NAT_FLT] = 1'b1; // [RL2]
            end else begin
              nxt_st.br[br_idx] = st_ff.src; // [RL2]
              nxt_st.stat[rmx_pkg::ST_BR_WR] = 1'b1;
            end
          end
          rmx_pkg::RMX_OP_FROM_IND: begin
            if (st_ff.src_nat) begin
              nxt_st.stat[rmx_pkg::ST_NAT_FLT] = 1'b1; // [RL8]
            end else if (ind_bus.reserved) begin
              nxt_st.stat[rmx_pkg::ST_RSV_FLT] = 1'b1; // [RL6]
            end else begin
              nxt_st.res = ind_bus.data; // [RL5] [RL8]
              nxt_st.stat[rmx_pkg::ST_GR_WR] = 1'b1;
            end
          end
          rmx_pkg::RMX_OP_FROM_IP: begin
            nxt_st.res = st_ff.ip; // [RL9]
            nxt_st.stat[rmx_pkg::ST_GR_WR] = 1'b1;
          end
          rmx_pkg::RMX_OP_FROM_PR: begin
            nxt_st.res = pred_bus.rd; // [RL10]
            nxt_st.stat[rmx_pkg::ST_GR_WR] = 1'b1;
          end
          rmx_pkg::RMX_OP_TO_PR: begin
            if (st_ff.src_nat) begin
              nxt_st.stat[rmx_pkg::ST_NAT_FLT] = 1'b1; // [RL14]
            end else begin
              pr_we   = 1'b1; // [RL11]
              pr_mask = mask_ext;
              pr_data = st_ff.src;
              nxt_st.stat[rmx_pkg::ST_PR_WR] = 1'b1;
            end
          end
          rmx_pkg::RMX_OP_TO_PR_ROT: begin
            pr_we   = 1'b1;
            pr_mask = {{rmx_pkg::ROT_PRED_N{1'b1}}, 16'h0000}; // [RL15]
            pr_data = rot_ext;
            nxt_st.stat[rmx_pkg::ST_PR_WR] = 1'b1;
          end
          rmx_pkg::RMX_OP_MOV_IMM: begin
            nxt_st.res = imm_ext + rmx_pkg::WIDE_RST; // [RL18]
            nxt_st.stat[rmx_pkg::ST_GR_WR] = 1'b1;
          end
          rmx_pkg::RMX_OP_MOV_GR: begin
            // the source token is copied through to the result token status bit
            nxt_st.res = st_ff.src + rmx_pkg::WIDE_RST; // [RL19]
            nxt_st.stat[rmx_pkg::ST_RES_NAT] = st_ff.src_nat;
            nxt_st.stat[rmx_pkg::ST_GR_WR]   = 1'b1;
          end
          default: begin
            // undefined op codes retire nothing and change no state except clearing the status
            retire = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign prdata  = st_ff.rdata;
  assign pready  = st_ff.rdy;
  assign pslverr = st_ff.err;

  ////////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic fire;
  logic fire_q;
  assign fire   = st_ff.pend && clk_en && qp_true;
  assign fire_q = st_ff.pend && clk_en && !qp_true;

  sequence s_go_write;
    clk_en && apb_acc && pwrite && !st_ff.err && paddr == rmx_pkg::OFF_CTRL
      && pstrb[1] && pwdata[rmx_pkg::CTRL_GO];
  endsequence

  sequence s_exec(logic [rmx_pkg::OP_W-1:0] code);
    fire && op_code == code;
  endsequence

  AST_GO_PEND: assert property (s_go_write |=> st_ff.pend) // [RL3]
    else $error("go write did not arm execution");

  AST_BR_READ: assert property ( // [RL1]
    s_exec(rmx_pkg::RMX_OP_FROM_BR) |=> st_ff.res == $past(sel_br)
      && !st_ff.stat[rmx_pkg::ST_RES_NAT] && st_ff.stat[rmx_pkg::ST_GR_WR])
    else $error("branch read result wrong");

  AST_BR_NAT: assert property ( // [RL2]
    s_exec(rmx_pkg::RMX_OP_TO_BR) && st_ff.src_nat |=> st_ff.stat[rmx_pkg::ST_NAT_FLT]
      && st_ff.br == $past(st_ff.br))
    else $error("branch write with token did not fault cleanly");

  AST_QP_OFF: assert property ( // [RL3]
    fire_q |=> st_ff.stat == 7'h40 && $stable(st_ff.res) && $stable(st_ff.br)
      && $stable(pred_bus.rd))
    else $error("false predicate changed state");

  AST_IND_ORDER: assert property ( // [RL8]
    s_exec(rmx_pkg::RMX_OP_FROM_IND) && st_ff.src_nat |=> st_ff.stat[rmx_pkg::ST_NAT_FLT]
      && !st_ff.stat[rmx_pkg::ST_RSV_FLT])
    else $error("index token fault not first");

  AST_IND_RSV: assert property ( // [RL6]
    s_exec(rmx_pkg::RMX_OP_FROM_IND) && !st_ff.src_nat && ind_bus.reserved
      |=> st_ff.stat[rmx_pkg::ST_RSV_FLT] && !st_ff.stat[rmx_pkg::ST_GR_WR])
    else $error("nonexistent index did not fault");

  AST_PMD_SAFE: assert property ( // [RL7]
    ind_bus.sel == rmx_pkg::RMX_IREG_PMD |-> !ind_bus.reserved)
    else $error("performance read faulted");

  AST_PR0_ONE: assert property (pred_bus.rd[0]) // [RL13]
    else $error("predicate zero not one");

  AST_ROT_STATIC: assert property ( // [RL15]
    s_exec(rmx_pkg::RMX_OP_TO_PR_ROT) |=> pred_bus.rd[15:0] == $past(pred_bus.rd[15:0])
      && pred_bus.rd[63:16] == $past(rot_ext[63:16]))
    else $error("rotating write wrong");

  AST_PR_NAT: assert property ( // [RL14]
    s_exec(rmx_pkg::RMX_OP_TO_PR) && st_ff.src_nat |=> $stable(pred_bus.rd)
      && st_ff.stat[rmx_pkg::ST_NAT_FLT])
    else $error("predicate write with token changed predicates");

  AST_IMM: assert property ( // [RL18]
    s_exec(rmx_pkg::RMX_OP_MOV_IMM) |=> st_ff.res[63:21] == {43{$past(st_ff.imm[21])}})
    else $error("immediate not sign extended");

  AST_PREADY_ONE: assert property (clk_en && st_ff.rdy |=> !st_ff.rdy)
    else $error("pready held beyond one cycle");

endmodule

// *** verification/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [15:0] ctrl;
    logic [31:0] imm;
    logic [63:0] src;
    logic        nat;
    logic [63:0] res;
    logic [6:0]  st;
    logic [7:0]  xa;
    logic [63:0] xv;
  } rmx_row_t;

  logic        pclk;
  logic        presetn;
  logic        clk_en;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          errors;
  int          check_count;
  int          cycles = 0;
  rmx_row_t    rows [16];

  rmx_top rmx_top_i (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pstrb   (pstrb),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // extra idle edge after release so no signal is assigned twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    // the master lives in the gated domain: phases advance only on enabled edges
    @(posedge pclk);
    while (clk_en !== 1'b1) @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 || clk_en !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd64(input logic [7:0] a, output logic [63:0] v);
    logic e;
    apb(1'b0, a, 32'h0, v[31:0], e);
    apb(1'b0, a + 8'h04, 32'h0, v[63:32], e);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // every test together needs well under this many cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [63:0] v;
    logic [31:0] r;
    logic        e;
    // identification value uses the design's default arbitrary tag
    rows = '{
      '{16'h0007, 32'h0020_0001, 64'h0, 1'b0, 64'hffff_ffff_ffe0_0001, 7'h02, 8'h00, 64'h0},
      '{16'h0008, 32'h0, 64'h0123_4567_89ab_cdef, 1'b1, 64'h0123_4567_89ab_cdef, 7'h03,
        8'h00, 64'h0},
      '{16'h0c01, 32'h0, 64'hdead_beef_0bad_f00d, 1'b0, 64'h0, 7'h04, 8'h30,
        64'hdead_beef_0bad_f00d},
      '{16'h0c01, 32'h0, 64'h1, 1'b1, 64'h0, 7'h10, 8'h30, 64'hdead_beef_0bad_f00d},
      '{16'h0c00, 32'h0, 64'h0, 1'b0, 64'hdead_beef_0bad_f00d, 7'h02, 8'h00, 64'h0},
      '{16'h0002, 32'h0, 64'hffff_ffff_ffff_ff03, 1'b0, 64'h5a5a_5a5a_5a5a_5a03, 7'h02,
        8'h00, 64'h0},
      '{16'h0002, 32'h0, 64'h105, 1'b0, 64'h0, 7'h20, 8'h00, 64'h0},
      '{16'h0002, 32'h0, 64'h105, 1'b1, 64'h0, 7'h10, 8'h00, 64'h0},
      '{16'h2002, 32'h0, 64'h80, 1'b0, 64'h0, 7'h02, 8'h00, 64'h0},
      '{16'h0003, 32'h0, 64'h0, 1'b0, 64'h0000_0040_0000_1230, 7'h02, 8'h00, 64'h0},
      '{16'h0005, 32'h0000_8002, '1, 1'b0, 64'h0, 7'h08, 8'h28, 64'hffff_ffff_ffff_0005},
      '{16'h0005, 32'h0000_ffff, 64'h0, 1'b1, 64'h0, 7'h10, 8'h28, 64'hffff_ffff_ffff_0005},
      '{16'h0006, 32'h0800_0001, 64'h0, 1'b0, 64'h0, 7'h08, 8'h28, 64'hffff_f800_0001_0005},
      '{16'h0004, 32'h0, 64'h0, 1'b0, 64'hffff_f800_0001_0005, 7'h02, 8'h00, 64'h0},
      '{16'h0018, 32'h0, 64'h1, 1'b0, 64'h0, 7'h40, 8'h1c, 64'hffff_f800_0001_0005},
      '{16'h0028, 32'h0, 64'h7, 1'b0, 64'h7, 7'h02, 8'h00, 64'h0}
    };
    presetn = 1'b0;
    clk_en  = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    pstrb   = 4'hf;
    errors  = 0;
    check_count = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd64(rmx_pkg::OFF_PR_LO, v);
    cmp(v, 64'h1);
    wr(rmx_pkg::OFF_IP_LO, 32'h0000_1230);
    wr(rmx_pkg::OFF_IP_HI, 32'h0000_0040);
    foreach (rows[i]) begin
      wr(rmx_pkg::OFF_IMM, rows[i].imm);
      wr(rmx_pkg::OFF_SRC_LO, rows[i].src[31:0]);
      wr(rmx_pkg::OFF_SRC_HI, rows[i].src[63:32]);
      wr(rmx_pkg::OFF_SRC_NT, {31'h0, rows[i].nat});
      wr(rmx_pkg::OFF_CTRL, {16'h0000, rows[i].ctrl | 16'h4000});
      apb(1'b0, rmx_pkg::OFF_STATUS, 32'h0, r, e);
      cmp({32'h0, r}, {57'h0, rows[i].st});
      if (rows[i].st[1]) begin
        rd64(rmx_pkg::OFF_RES_LO, v);
        cmp(v, rows[i].res);
      end
      if (rows[i].xa != 8'h00) begin
        rd64(rows[i].xa, v);
        cmp(v, rows[i].xv);
      end
    end
    // unmapped and misaligned places answer with an error
    apb(1'b0, 8'h38, 32'h0, r, e);
    cmp({r, 31'h0, e}, 64'h1);
    apb(1'b1, 8'h02, 32'hffff_ffff, r, e);
    cmp({63'h0, e}, 64'h1);
    // enable held low through the access phase: pready must stand, write lands once
    fork
      begin
        @(posedge pclk);
        clk_en <= 1'b0;
        repeat (3) @(posedge pclk);
        clk_en <= 1'b1;
      end
    join_none
    wr(rmx_pkg::OFF_IMM, 32'h1357_9bdf);
    apb(1'b0, rmx_pkg::OFF_IMM, 32'h0, r, e);
    cmp({31'h0, e, r}, 64'h0000_0000_1357_9bdf);
    // second reset mid-run, then a write to a read-only word is ignored
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    wr(rmx_pkg::OFF_RES_LO, 32'hffff_ffff);
    rd64(rmx_pkg::OFF_RES_LO, v);
    cmp(v, 64'h0);
    rd64(rmx_pkg::OFF_PR_LO, v);
    cmp(v, 64'h1);
    give_verdict();
  end
endmodule
